// ### iwd_watchdog.sv
// module: i/o port watchdog timer core with reset, nmi and irq expiry actions
// Behaviour
// (RQ1) on expiry perform selected reset or interrupt
// (RQ2) action codes 0..4: reset, nmi, irq10, irq11, irq15
// (RQ3) timeout byte 01h..FFh means 1..255 seconds
// (RQ4) timeout held as plain 8-bit binary count
// (RQ5) software writes action then nonzero timeout
// (RQ6) timeout rewrite refreshes and reloads the count
// (RQ7) read of port 80h disables the watchdog
// (RQ8) one-second tick counts down, expiry at zero
`timescale 1ns/1ps
`default_nettype none
module iwd_watchdog #(
    parameter int unsigned TICK_CYCLES = iwd_pkg::TICK_CYCLES
) (
    input wire logic clk_in,            // 50 MHz board clock
    input wire logic rst_in,            // sync reset, active high
    input wire logic [15:0] io_addr_in, // i/o port address
    input wire logic [7:0] io_wdata_in, // write data byte
    input wire logic io_wr_in,          // write strobe, one cycle
    input wire logic io_rd_in,          // read strobe, one cycle
    output logic [7:0] io_rdata_out,    // read data (remaining seconds)
    output logic running_out,           // watchdog armed
    output logic sys_reset_out,         // system reset pulse
    output logic nmi_out,               // nmi pulse
    output logic irq10_out,             // irq10 pulse
    output logic irq11_out,             // irq11 pulse
    output logic irq15_out              // irq15 pulse
);
    // ==========================================================
    // one-second time base
    iwd_tick_if tk ();
    iwd_prescaler #(.CYCLES(TICK_CYCLES)) u_pre (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .tk(tk)
    );

    // ==========================================================
    // port decode
    logic wr_action;
    logic wr_timeout;
    logic rd_disable;
    assign wr_action = io_wr_in && (io_addr_in == iwd_pkg::PORT_ACTION);
    assign wr_timeout = io_wr_in && (io_addr_in == iwd_pkg::PORT_TIMEOUT);
    assign rd_disable = io_rd_in && (io_addr_in == iwd_pkg::PORT_DISABLE);

    // ==========================================================
    // state
    iwd_pkg::iwd_state_t state;
    iwd_pkg::iwd_state_t next_state;
    logic [7:0] action;
    logic [7:0] next_action;
    logic [7:0] count;
    logic [7:0] next_count;
    logic [4:0] pulse;
    logic [4:0] next_pulse;
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic restart;
    logic [4:0] next_outs;
    logic [4:0] outs;

    assign tk.restart = restart;

    // ==========================================================
    // next-state logic
    // a rewrite always wins over a tick in the same cycle, so a late refresh
    // never loses a second to the old count
    always_comb
    begin
        next_state = state;
        next_action = action;
        next_count = count;
        next_pulse = pulse;
        next_outs = 5'h00;
        restart = 1'b0;
        next_rdata = rdata;
        if (wr_action)
        begin
            next_action = io_wdata_in; // see (RQ2) (RQ5)
        end
        case (state)
            iwd_pkg::ST_IDLE:
            begin
                if (wr_timeout && io_wdata_in != 8'h00)
                begin
                    next_count = io_wdata_in; // see (RQ3) (RQ4)
                    restart = 1'b1;
                    next_state = iwd_pkg::ST_RUN;
                end
            end
            iwd_pkg::ST_RUN:
            begin
                if (rd_disable)
                begin
                    next_state = iwd_pkg::ST_IDLE; // see (RQ7)
                    next_count = 8'h00;
                end
                else if (wr_timeout)
                begin
                    // a zero rewrite stops the timer rather than firing at once
                    next_count = io_wdata_in; // see (RQ6)
                    restart = 1'b1;
                    if (io_wdata_in == 8'h00)
                    begin
                        next_state = iwd_pkg::ST_IDLE;
                    end
                end
                else if (tk.tick)
                begin
                    next_count = count - 8'h01; // see (RQ8)
                    if (count == 8'h01)
                    begin
                        next_state = iwd_pkg::ST_FIRE;
                        next_pulse = iwd_pkg::PULSE_COUNT;
                    end
                end
            end
            iwd_pkg::ST_FIRE:
            begin
                // outputs held a few cycles so slow edge logic sees them
                // codes above four fire nothing; the timer just drops back to idle
                case (action)
                    iwd_pkg::ACT_RESET:
                    begin
                        next_outs = 5'h01; // see (RQ1) (RQ2)
                    end
                    iwd_pkg::ACT_NMI:
                    begin
                        next_outs = 5'h02; // see (RQ1) (RQ2)
                    end
                    iwd_pkg::ACT_IRQ10:
                    begin
                        next_outs = 5'h04; // see (RQ1) (RQ2)
                    end
                    iwd_pkg::ACT_IRQ11:
                    begin
                        next_outs = 5'h08; // see (RQ1) (RQ2)
                    end
                    iwd_pkg::ACT_IRQ15:
                    begin
                        next_outs = 5'h10; // see (RQ1) (RQ2)
                    end
                    default:
                    begin
                        next_outs = 5'h00;
                    end
                endcase
                next_pulse = pulse - 5'h01;
                if (pulse == 5'h01)
                begin
                    next_state = iwd_pkg::ST_IDLE;
                end
            end
            default:
            begin
                next_state = iwd_pkg::ST_IDLE;
            end
        endcase
        // the disabling read also reports the seconds that were left
        if (rd_disable)
        begin
            next_rdata = count;
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            state <= iwd_pkg::ST_IDLE;
            action <= iwd_pkg::ACTION_RESET_VALUE;
            count <= iwd_pkg::TIMEOUT_RESET_VALUE;
            pulse <= 5'h00;
            outs <= 5'h00;
            rdata <= 8'h00;
        end
        else
        begin
            state <= next_state;
            action <= next_action;
            count <= next_count;
            pulse <= next_pulse;
            outs <= next_outs;
            rdata <= next_rdata;
        end
    end

    // ==========================================================
    // outputs
    // taken from the next state so the flag falls in step with the state change
    logic running_q;
    logic next_running;

    always_comb
    begin
        next_running = (next_state == iwd_pkg::ST_RUN);
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            running_q <= 1'b0;
        end
        else
        begin
            running_q <= next_running;
        end
    end

    assign running_out = running_q;
    assign io_rdata_out = rdata;
    assign sys_reset_out = outs[0];
    assign nmi_out = outs[1];
    assign irq10_out = outs[2];
    assign irq11_out = outs[3];
    assign irq15_out = outs[4];
endmodule : iwd_watchdog
`default_nettype wire

// ### iwd_pkg.sv
// package: port addresses, action codes, timing constants for the i/o port watchdog
package iwd_pkg;
    localparam logic [15:0] PORT_DISABLE = 16'h0080;
    localparam logic [15:0] PORT_TIMEOUT = 16'h0443;
    localparam logic [15:0] PORT_ACTION = 16'h0444;
    localparam logic [7:0] ACT_RESET = 8'h00;
    localparam logic [7:0] ACT_NMI = 8'h01;
    localparam logic [7:0] ACT_IRQ10 = 8'h02;
    localparam logic [7:0] ACT_IRQ11 = 8'h03;
    localparam logic [7:0] ACT_IRQ15 = 8'h04;
    localparam logic [7:0] ACTION_RESET_VALUE = 8'h00;
    localparam logic [7:0] TIMEOUT_RESET_VALUE = 8'h00;
    localparam int CLK_HZ = 50000000;
    localparam int TICK_PERIOD_S = 1;
    localparam int TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
    localparam int TICK_W = 26;
    localparam int PULSE_CYCLES = 16;
    localparam logic [4:0] PULSE_COUNT = 5'(PULSE_CYCLES);
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_FIRE = 2'b11
    } iwd_state_t;
endpackage : iwd_pkg

// ### iwd_tick_if.sv
// interface: one-second tick between prescaler and watchdog core
`timescale 1ns/1ps
`default_nettype none
interface iwd_tick_if;
    logic restart;
    logic tick;
    modport source (input restart, output tick);
    modport sink (output restart, input tick);
endinterface : iwd_tick_if
`default_nettype wire

// ### iwd_prescaler.sv
// module: divides the board clock to a one-second tick, restartable
`timescale 1ns/1ps
`default_nettype none
module iwd_prescaler #(
    parameter int unsigned CYCLES = 50000000
) (
    input wire logic clk_in,            // board clock
    input wire logic rst_in,            // sync reset, active high
    iwd_tick_if.source tk               // tick link
);
    logic [iwd_pkg::TICK_W-1:0] cnt;
    logic [iwd_pkg::TICK_W-1:0] next_cnt;
    logic next_tick;
    logic tick_q;

    always_comb
    begin
        next_tick = 1'b0;
        if (tk.restart)
        begin
            next_cnt = '0;
        end
        else if (cnt == iwd_pkg::TICK_W'(CYCLES - 1))
        begin
            next_cnt = '0;
            next_tick = 1'b1;
        end
        else
        begin
            next_cnt = cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            cnt <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            tick_q <= next_tick;
        end
    end

    assign tk.tick = tick_q;
endmodule : iwd_prescaler
`default_nettype wire

// ### iwd_monitor.sv
// checker: port-level properties of the i/o port watchdog
`timescale 1ns/1ps
`default_nettype none
module iwd_monitor #(
    parameter int unsigned TICK_CYCLES = 10
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [15:0] io_addr_in,
    input wire logic [7:0] io_wdata_in,
    input wire logic io_wr_in,
    input wire logic io_rd_in,
    input wire logic [7:0] io_rdata_out,
    input wire logic running_out,
    input wire logic sys_reset_out,
    input wire logic nmi_out,
    input wire logic irq10_out,
    input wire logic irq11_out,
    input wire logic irq15_out
);
    // ========
    // properties
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    wire logic [4:0] act = {sys_reset_out, nmi_out, irq10_out, irq11_out, irq15_out};
    wire logic any_act = |act;
    wire logic wr_to = io_wr_in && io_addr_in == iwd_pkg::PORT_TIMEOUT;
    wire logic rd_off = io_rd_in && io_addr_in == iwd_pkg::PORT_DISABLE;
    AST_ARM: assert property (wr_to && io_wdata_in != 8'h00 |=> running_out)
        else $error("nonzero timeout write did not arm");
    AST_ZERO: assert property (wr_to && io_wdata_in == 8'h00 |=> !running_out)
        else $error("zero timeout write left timer armed");
    AST_OFF: assert property (rd_off |=> !running_out)
        else $error("disable read did not stop timer");
    AST_RDATA: assert property (!rd_off |=> $stable(io_rdata_out))
        else $error("read data moved without a read");
    AST_ONE: assert property ($onehot0(act))
        else $error("more than one expiry output");
    AST_PULSE: assert property ($rose(any_act) |=> any_act[*8] ##8 !any_act)
        else $error("expiry pulse width wrong");
    AST_CAUSE: assert property ($rose(any_act) |-> !running_out &&
        ($past(running_out, 1) || $past(running_out, 2) || $past(running_out, 3)))
        else $error("expiry without armed timer");
    AST_HOLD: assert property ((wr_to && io_wdata_in != 8'h00) ##1
        (!(io_wr_in || io_rd_in))[*8] |-> running_out)
        else $error("timer ended before one second");
    cover property ($rose(sys_reset_out));
    cover property ($rose(nmi_out));
    cover property ($rose(irq15_out));
    cover property (running_out && wr_to && io_wdata_in == 8'h00);
endmodule : iwd_monitor
bind iwd_watchdog iwd_monitor #(.TICK_CYCLES(TICK_CYCLES)) iwd_monitor_i (.*);
`default_nettype wire

// ### iwd_host.sv
// model: host cpu issuing single-cycle i/o port strobes
`timescale 1ns/1ps
`default_nettype none
module iwd_host (
    input wire logic clk_in,         // board clock
    output logic [15:0] io_addr_out, // port address
    output logic [7:0] io_wdata_out, // write byte
    output logic io_wr_out,          // write strobe
    output logic io_rd_out           // read strobe
);
    // ========
    // bus cycles
    initial
    begin
        io_addr_out = 16'h0000;
        io_wdata_out = 8'h00;
        io_wr_out = 1'b0;
        io_rd_out = 1'b0;
    end
    // write when wr is set, otherwise read; a read of PORT_DISABLE disables the timer
    task acc(input logic wr, input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_in);
        io_addr_out = a;
        io_wdata_out = d;
        io_wr_out = wr;
        io_rd_out = !wr;
        @(negedge clk_in);
        io_wr_out = 1'b0;
        io_rd_out = 1'b0;
        // released bus shows a changed pattern, not the stale value
        io_addr_out = ~a;
        io_wdata_out = ~d;
    endtask : acc
    // action before period
    task arm(input logic [7:0] code, input logic [7:0] n);
        acc(1'b1, iwd_pkg::PORT_ACTION, code);
        acc(1'b1, iwd_pkg::PORT_TIMEOUT, n);
    endtask : arm
endmodule : iwd_host
`default_nettype wire

// ### tb_top.sv
// testbench: i/o port watchdog with host model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int TC = 10;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    wire logic [15:0] addr;
    wire logic [7:0] wdata;
    wire logic wr;
    wire logic rd;
    wire logic [7:0] rdata;
    wire logic run;
    wire logic [4:0] act;
    int miscompares = 0;
    int n_checks = 0;
    int seed = 32'h0733;
    always #10 clk_in = ~clk_in;
    iwd_host iwd_host_i (.clk_in(clk_in), .io_addr_out(addr), .io_wdata_out(wdata),
        .io_wr_out(wr), .io_rd_out(rd));
    iwd_watchdog #(.TICK_CYCLES(TC)) iwd_watchdog_i (.clk_in(clk_in), .rst_in(rst_in),
        .io_addr_in(addr), .io_wdata_in(wdata), .io_wr_in(wr), .io_rd_in(rd),
        .io_rdata_out(rdata), .running_out(run), .sys_reset_out(act[4]), .nmi_out(act[3]),
        .irq10_out(act[2]), .irq11_out(act[1]), .irq15_out(act[0]));
    // ========
    // checking
    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    function automatic logic [7:0] sel_vec(input logic [7:0] code);
        return (code < 8'h05) ? 8'h10 >> code : 8'h00;
    endfunction : sel_vec
    task finish_test;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test
    // first is the period armed with; a differing n is written over it mid-count
    task run_case(input logic [7:0] code, input logic [7:0] n, input logic [7:0] first);
        int t;
        iwd_host_i.arm(code, first);
        chk("armed", 8'h01, {7'h00, run});
        if (first != n)
        begin
            repeat (5) @(negedge clk_in);
            iwd_host_i.acc(1'b1, iwd_pkg::PORT_TIMEOUT, n);
            chk("rearmed", 8'h01, {7'h00, run});
        end
        t = 0;
        // invalid codes stay silent, so the bound is also the wait for them
        while (act === 5'h00 && t < n * TC + 40)
        begin
            @(negedge clk_in);
            t++;
        end
        chk("action", sel_vec(code), {3'h0, act});
        if (sel_vec(code) != 8'h00 && act === 5'h00)
            finish_test();
        if (sel_vec(code) != 8'h00)
            chk("delay", 8'h01, {7'h00, t >= n * TC - 1 && t <= n * TC + 4});
        repeat (20) @(negedge clk_in);
        chk("idle after", 8'h00, {2'h0, run, act});
    endtask : run_case
    // ========
    // main sequence
    initial
    begin
        logic [7:0] c;
        logic [7:0] n;
        logic [7:0] f;
        repeat (12) @(negedge clk_in);
        rst_in = 1'b0;
        chk("reset", 8'h00, {2'h0, run, act});
        iwd_host_i.acc(1'b1, 16'h0100 + 16'($unsigned($random(seed)) % 256), 8'h05);
        iwd_host_i.acc(1'b1, iwd_pkg::PORT_TIMEOUT, 8'h00);
        chk("idle", 8'h00, {7'h0, run});
        for (int i = 0; i < 9; i++)
        begin
            c = (i < 6) ? 8'(i) : 8'($unsigned($random(seed)) % 5);
            n = (i < 6) ? 8'h01 : 8'(1 + $unsigned($random(seed)) % 3);
            f = (i < 6) ? n : 8'(1 + $unsigned($random(seed)) % 3);
            run_case(c, n, f);
        end
        // corners: full period, a long period cut short, a short one stretched
        run_case(iwd_pkg::ACT_IRQ15, 8'hFF, 8'hFF);
        run_case(iwd_pkg::ACT_IRQ11, 8'h01, 8'hFF);
        run_case(iwd_pkg::ACT_NMI, 8'h03, 8'h01);
        // a read of any other port must leave the timer alone; a zero rewrite stops it
        iwd_host_i.arm(iwd_pkg::ACT_IRQ10, 8'h02);
        iwd_host_i.acc(1'b0, 16'h0200 + 16'($unsigned($random(seed)) % 256), 8'h00);
        chk("foreign read", 8'h20, {2'h0, run, act});
        iwd_host_i.acc(1'b1, iwd_pkg::PORT_TIMEOUT, 8'h00);
        chk("zero write", 8'h00, {7'h0, run});
        repeat (40) @(negedge clk_in);
        chk("stopped", 8'h00, {2'h0, run, act});
        iwd_host_i.arm(iwd_pkg::ACT_NMI, 8'h02);
        repeat (4)
        begin
            repeat (12) @(negedge clk_in);
            iwd_host_i.acc(1'b1, iwd_pkg::PORT_TIMEOUT, 8'h02);
        end
        chk("refresh", 8'h20, {2'h0, run, act});
        iwd_host_i.acc(1'b0, iwd_pkg::PORT_DISABLE, 8'h00);
        @(negedge clk_in);
        chk("remaining", 8'h02, rdata);
        repeat (60) @(negedge clk_in);
        chk("disabled", 8'h00, {2'h0, run, act});
        // reset in mid-count: everything clears and the action falls back to its default
        iwd_host_i.arm(iwd_pkg::ACT_IRQ15, 8'h02);
        repeat (8) @(negedge clk_in);
        rst_in = 1'b1;
        repeat (3) @(negedge clk_in);
        rst_in = 1'b0;
        chk("mid reset", 8'h00, {2'h0, run, act});
        chk("rdata reset", 8'h00, rdata);
        iwd_host_i.acc(1'b1, iwd_pkg::PORT_TIMEOUT, 8'h01);
        repeat (13) @(negedge clk_in);
        chk("default action", sel_vec(iwd_pkg::ACTION_RESET_VALUE), {3'h0, act});
        repeat (20) @(negedge clk_in);
        chk("end", 8'h00, {2'h0, run, act});
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
